// ===== rtl/tws_pkg.sv
// Constants and types shared by the two-wire slave port.
// Assumes a 100 MHz pclk; the serial bus pins arrive unsynchronised.
package tws_pkg;

  localparam int CLK_KHZ    = 100000;
  localparam int TOUT_MS    = 35;
  localparam int TOUT_CYC   = TOUT_MS * CLK_KHZ;
  localparam int CLR_PULSES = 9;
  localparam int REG_DEPTH  = 256;
  localparam int AW         = 12;

  // Register offsets
  localparam logic [AW-1:0] OFS_CTRL = 12'h000;
  localparam logic [AW-1:0] OFS_ADDR = 12'h004;
  localparam logic [AW-1:0] OFS_STAT = 12'h008;

  // Control field positions
  localparam int C_SEL = 0;
  localparam int C_SUP = 2;
  localparam int C_CKF = 3;
  localparam int C_CKW = 4;
  localparam int C_DWK = 5;
  localparam int C_MSK = 6;
  localparam int C_HSH = 7;
  localparam int C_TOE = 8;
  localparam int C_ARV = 9;
  localparam int C_MW  = 10;
  localparam int C_IFR = 11;
  localparam int PG_BIT = 1;

  // Reset values
  localparam logic [11:0] CTRL_RST     = 12'h041;
  localparam logic [7:0]  BASE_ADR_RST = 8'hB4;
  localparam logic [7:0]  ALT_ADR_RST  = 8'hB2;
  localparam logic [7:0]  PAGE_RST     = 8'h00;

  localparam logic [1:0] SEL_SERIAL = 2'h1;
  localparam logic [4:0] MCODE      = 5'h01;
  localparam logic [2:0] FLT_STD    = 3'h1;
  localparam logic [2:0] FLT_HS     = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_DATA, ST_TX, ST_MACK, ST_IGN
  } tws_state_t;

endpackage

// ===== rtl/tws_filt.sv
// Two-flop synchroniser followed by a stable-count glitch filter.
// Assumes din is asynchronous to pclk and idles high.
module tws_filt #(
  parameter int CW = 3
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          din,
  input  wire logic [CW-1:0] len,
  output logic               dout
);

  logic          meta;
  logic          sync;
  logic [CW-1:0] cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b1;
      sync <= 1'b1;
      cnt  <= '0;
      dout <= 1'b1;
    end
    else
    begin
      meta <= din;
      sync <= meta;
      if (sync == dout)
        cnt <= '0;
      else if (cnt >= len)
      begin
        dout <= sync;
        cnt  <= '0;
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

endmodule

// ===== rtl/tws_slave_port.sv
// Two-wire slave port with paged register access and an APB config slave.
// Assumes an external pull-up on both lines and a master driving the clock.
module tws_slave_port #(
  parameter int TOUT_CYC  = tws_pkg::TOUT_CYC,
  parameter int REG_DEPTH = tws_pkg::REG_DEPTH
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [tws_pkg::AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_n,
  input  wire logic                   shutdown_request_pin_n,
  output logic                        interrupt_request_out_n,
  output logic                        wakeup_event,
  output logic                        clock_pin_function_en,
  output logic                        clock_pin_wakeup_en,
  output logic                        data_pin_supply_sel,
  output logic                        hs_mode
);
  import tws_pkg::*;

  localparam int DW = $clog2(REG_DEPTH);
  localparam int TW = $clog2(TOUT_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [11:0]   ctrl;
  logic [7:0]    base_addr;
  logic [7:0]    alt_addr;
  logic          addr_event;
  logic [7:0]    page_reg;
  tws_state_t    state;
  logic [2:0]    bitcnt;
  logic [7:0]    rxsh;
  logic [7:0]    txsh;
  logic [7:0]    ptr;
  logic          bank;
  logic          ack_pend;
  logic          ack_on;
  logic          hs_once;
  logic [3:0]    clr_cnt;
  logic [TW-1:0] tcnt;
  logic          scl_f;
  logic          sda_f;
  logic          scl_q;
  logic          sda_q;
  logic          shut_m;
  logic          shut_s;
  logic [7:0]    regmem [0:2*REG_DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning
  wire [2:0] flt_len = hs_mode ? FLT_HS : FLT_STD;

  tws_filt #(.CW(3)) u_scl (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (scl_in),
    .len     (flt_len),
    .dout    (scl_f)
  );

  tws_filt #(.CW(3)) u_sda (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (sda_in),
    .len     (flt_len),
    .dout    (sda_f)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      shut_m <= 1'b1;
      shut_s <= 1'b1;
    end
    else
    begin
      scl_q  <= scl_f;
      sda_q  <= sda_f;
      shut_m <= shutdown_request_pin_n;
      shut_s <= shut_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus event decode
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire start    = sda_q & ~sda_f & scl_f & scl_q;
  wire stop     = ~sda_q & sda_f & scl_f & scl_q;
  wire port_en  = ctrl[C_SEL+1:C_SEL] == SEL_SERIAL;
  wire tout_hit = ctrl[C_TOE] & (tcnt == TW'(TOUT_CYC));
  wire clr_hit  = clr_cnt == 4'(CLR_PULSES);
  wire shut_rst = ctrl[C_IFR] & ~shut_s;
  wire prst     = ~port_en | tout_hit | clr_hit | shut_rst;
  wire bit_rise = scl_rise & ~ack_on & ~(prst | start | stop);
  wire byte_done = bit_rise & (bitcnt == 3'h7);
  wire [7:0] rx_byte = {rxsh[6:0], sda_f};
  wire wr_match = rx_byte[7:1] == base_addr[7:1];
  wire alt_match = rx_byte[7:1] == alt_addr[7:1];
  wire in_addr  = (state == ST_ADDR) & byte_done;
  wire mc_hit   = in_addr & (rx_byte[7:3] == MCODE);
  wire hit_now  = in_addr & ~mc_hit & (wr_match | alt_match);
  wire bank_nx  = alt_match | page_reg[PG_BIT];
  wire ptr_ok   = {1'b0, ptr} < 9'(REG_DEPTH);
  wire mem_we   = (state == ST_DATA) & byte_done & (ptr != 8'h00) & ptr_ok;

  function automatic logic [7:0] rd_byte(input logic b, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == 8'h00)
      v = page_reg;
    else if ({1'b0, a} < 9'(REG_DEPTH))
      v = regmem[{b, a[DW-1:0]}];
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= ST_IDLE;
      bitcnt   <= 3'h0;
      rxsh     <= 8'h00;
      txsh     <= 8'h00;
      ptr      <= 8'h00;
      bank     <= 1'b0;
      ack_pend <= 1'b0;
      ack_on   <= 1'b0;
      sda_oe_n <= 1'b1;
      hs_once  <= 1'b0;
      page_reg <= PAGE_RST;
    end
    else if (prst | start | stop)
    begin
      state    <= (start & ~prst) ? ST_ADDR : ST_IDLE;
      bitcnt   <= 3'h0;
      ack_pend <= 1'b0;
      ack_on   <= 1'b0;
      sda_oe_n <= 1'b1;
      if (prst | stop)
        hs_once <= 1'b0;
      if (stop & ctrl[C_ARV])
        page_reg <= 8'h00;
    end
    else if (bit_rise)
    begin
      bitcnt <= bitcnt + 3'h1;
      rxsh   <= rx_byte;
      case (state)
        ST_ADDR:
          if (mc_hit)
          begin
            hs_once <= 1'b1;
            state   <= ST_IGN;
          end
          else if (hit_now)
          begin
            ack_pend <= 1'b1;
            bank     <= bank_nx;
            state    <= rx_byte[0] ? ST_TX : ST_REG;
            txsh     <= rd_byte(bank_nx, ptr);
          end
          else if (byte_done)
            state <= ST_IGN;
        ST_REG:
          if (byte_done)
          begin
            ptr      <= rx_byte;
            ack_pend <= 1'b1;
            state    <= ST_DATA;
          end
        ST_DATA:
          if (byte_done)
          begin
            ack_pend <= 1'b1;
            if (ptr == 8'h00)
              page_reg <= rx_byte;
            if (ctrl[C_MW])
              state <= ST_REG;
            else
              ptr <= ptr + 8'h01;
          end
        ST_TX:
          if (byte_done)
            state <= ST_MACK;
        ST_MACK:
        begin
          bitcnt <= 3'h0;
          if (!sda_f)
          begin
            ptr   <= ptr + 8'h01;
            txsh  <= rd_byte(bank, ptr + 8'h01);
            state <= ST_TX;
          end
          else
            state <= ST_IGN;
        end
        default:
          state <= state;
      endcase
    end
    else if (scl_fall)
    begin
      if (ack_pend)
      begin
        sda_oe_n <= 1'b0;
        ack_pend <= 1'b0;
        ack_on   <= 1'b1;
      end
      else if (ack_on | (state == ST_TX))
      begin
        ack_on   <= 1'b0;
        sda_oe_n <= (state != ST_TX) | txsh[7];
        if (state == ST_TX)
          txsh <= {txsh[6:0], 1'b0};
      end
      else
        sda_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (mem_we)
      regmem[{bank, ptr[DW-1:0]}] <= rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout and bus clear counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tcnt <= '0;
    else if (scl_rise | scl_fall | (state == ST_IDLE) | prst)
      tcnt <= '0;
    else if (!tout_hit)
      tcnt <= tcnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_cnt <= 4'h0;
    else if (prst | start | stop)
      clr_cnt <= 4'h0;
    else if (scl_rise)
      clr_cnt <= (sda_f | byte_done) ? 4'h0 : clr_cnt + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register slave
  wire setup   = psel & ~penable;
  wire wr_do   = psel & penable & pready & pwrite;
  wire is_ctrl = paddr == OFS_CTRL;
  wire is_addr = paddr == OFS_ADDR;
  wire is_stat = paddr == OFS_STAT;
  wire mapped  = is_ctrl | is_addr | is_stat;
  wire [31:0] stat_word = {16'h0000, page_reg, 4'h0, ~sda_oe_n,
                           state != ST_IDLE, hs_mode, addr_event};
  wire [31:0] rd_mux = is_ctrl ? {20'h00000, ctrl} :
                       is_addr ? {16'h0000, alt_addr, base_addr} :
                       is_stat ? stat_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl      <= CTRL_RST;
      base_addr <= BASE_ADR_RST;
      alt_addr  <= ALT_ADR_RST;
    end
    else if (wr_do & is_ctrl)
      ctrl <= pwdata[11:0];
    else if (wr_do & is_addr)
    begin
      base_addr <= pwdata[7:0];
      alt_addr  <= pwdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flag and outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_event <= 1'b0;
    else if (hit_now)
      addr_event <= 1'b1;
    else if (wr_do & is_stat & pwdata[0])
      addr_event <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_request_out_n <= 1'b1;
      wakeup_event            <= 1'b0;
      clock_pin_function_en   <= 1'b0;
      clock_pin_wakeup_en     <= 1'b0;
      data_pin_supply_sel     <= 1'b0;
      hs_mode                 <= 1'b0;
      sda_out                 <= 1'b0;
    end
    else
    begin
      interrupt_request_out_n <= ~(addr_event & ~ctrl[C_MSK]);
      wakeup_event            <= hit_now & ctrl[C_DWK];
      clock_pin_function_en   <= ctrl[C_CKF] & ~port_en;
      clock_pin_wakeup_en     <= ctrl[C_CKW] & ~port_en;
      data_pin_supply_sel     <= ctrl[C_SUP];
      hs_mode                 <= ctrl[C_HSH] | hs_once;
      sda_out                 <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_mcode;
    mc_hit ##1 hs_once;
  endsequence

  sequence s_match;
    hit_now ##1 ack_pend;
  endsequence

  port_off_a: assert property (!port_en |=> sda_oe_n)
    else $error("port drives data while disabled");
  clk_pin_a: assert property (port_en |=> !clock_pin_function_en && !clock_pin_wakeup_en)
    else $error("clock pin function left on");
  irq_set_a: assert property (hit_now && !ctrl[C_MSK] |-> ##2 !interrupt_request_out_n)
    else $error("interrupt missing after match");
  wake_a: assert property (hit_now && ctrl[C_DWK] |=> wakeup_event)
    else $error("wakeup missing after match");
  hs_code_a: assert property (s_mcode |=> hs_mode)
    else $error("master code did not enter high speed");
  tout_a: assert property (tout_hit |=> state == ST_IDLE && sda_oe_n)
    else $error("timeout did not reset port");
  clear_a: assert property (clr_hit |=> sda_oe_n && clr_cnt == 4'h0)
    else $error("bus clear did not release data");
  ack_drv_a: assert property (s_match |-> ##[1:1000] !sda_oe_n)
    else $error("address not acknowledged");
  sda_chg_a: assert property ($fell(sda_oe_n) |-> !scl_f)
    else $error("data driven while clock high");
  page_rtn_a: assert property (stop && ctrl[C_ARV] && !prst |=> page_reg == 8'h00)
    else $error("page did not return to zero");

endmodule

// ===== tb/tws_mst.sv
// Two-wire bus master model: drives the serial clock and releases or pulls data.
// Assumes the bench resolves the data wire with a pull-up from all enables.
module tws_mst (
  output logic       scl,
  output logic       sda_rel,
  input  wire logic  sda,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25;
  event got;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
    rx_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Start with clock high; waits for any ack to be released first
  task automatic start();
    sda_rel = 1'b1;
    #(2*Q);
    scl = 1'b1;
    #Q;
    sda_rel = 1'b0;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_rel = 1'b1;
    #(2*Q);
  endtask
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      rx_byte[i] = r;
    end
    bit_io(~ack, r);
    -> got;
  endtask
endmodule

// ===== tb/test_paged_two_wire_slave_port.sv
// Self-checking bench: APB configuration plus serial traffic from a master model.
// Assumes tws_pkg offsets and a pull-up on the shared data line.
module test_paged_two_wire_slave_port;
  timeunit 1ns;
  timeprecision 10ps;
  import tws_pkg::*;
  typedef struct packed {
    logic        err;
    logic [31:0] msk;
    logic [31:0] val;
  } tws_exp_t;
  localparam logic [7:0] WA = 8'hB4;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0]   pwdata = '0;
  logic          shut_n = 1'b1;
  logic [31:0]   prdata;
  logic          pready, pslverr, scl, m_rel, sda_out, sda_oe_n, irq_n, wake;
  logic          ckf, ckw, sup, hs, a;
  logic [7:0]    rx_byte;
  logic [7:0]    d [3];
  wire logic     sda_w = m_rel & (sda_oe_n | sda_out);
  int            n_fail = 0;
  int            checked = 0;
  int            wake_n = 0;
  int            seed;
  tws_exp_t      exp_q[$];
  tws_exp_t      e_m;
  logic [7:0]    ser_q[$];
  always #5 pclk = ~pclk;
  tws_slave_port #(.TOUT_CYC(2000), .REG_DEPTH(64)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .shutdown_request_pin_n(shut_n), .interrupt_request_out_n(irq_n),
    .wakeup_event(wake), .clock_pin_function_en(ckf), .clock_pin_wakeup_en(ckw),
    .data_pin_supply_sel(sup), .hs_mode(hs));
  tws_mst mdl_u (.scl(scl), .sda_rel(m_rel), .sda(sda_w), .rx_byte(rx_byte));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [AW-1:0] ad, input logic [31:0] dv,
                     input logic [31:0] m);
    tws_exp_t e;
    int n;
    e.err = (ad != OFS_CTRL) && (ad != OFS_ADDR) && (ad != OFS_STAT);
    e.msk = m;
    e.val = dv & m;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wr ? dv : 32'h0000_0000;
    if (!wr)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] v);
    apb(1'b1, OFS_CTRL, v, 32'h0);
    repeat (3) @(posedge pclk);
  endtask
  task automatic sstart();
    @(posedge pclk);
    #3.3;
    mdl_u.start();
  endtask
  task automatic sstop();
    @(posedge pclk);
    #3.3;
    mdl_u.stop();
    repeat (3) @(posedge pclk);
  endtask
  task automatic sw(input logic [7:0] q[$], input logic ea);
    logic k;
    sstart();
    foreach (q[i])
    begin
      mdl_u.wr_byte(q[i], k);
      check({31'h0, k}, {31'h0, ea});
      if (!k)
        break;
    end
    sstop();
  endtask
  task automatic sr(input logic [7:0] rg, input logic [7:0] q[$]);
    logic k;
    sstart();
    mdl_u.wr_byte(WA, k);
    mdl_u.wr_byte(rg, k);
    sstart();
    mdl_u.wr_byte(WA | 8'h01, k);
    check({31'h0, k}, 32'h1);
    foreach (q[i])
    begin
      ser_q.push_back(q[i]);
      mdl_u.rd_byte(i < q.size() - 1);
    end
    sstop();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
    begin
      e_m = exp_q.pop_front();
      check({31'h0, pslverr}, {31'h0, e_m.err});
      check(prdata & e_m.msk, e_m.val);
    end
  always @(mdl_u.got)
    check({24'h0, rx_byte}, {24'h0, ser_q.pop_front()});
  always @(posedge pclk)
    if (wake === 1'b1)
      wake_n <= wake_n + 1;
  initial
  begin
    #500000;
    n_fail++;
    final_report();
  end
  initial
  begin
    seed = 29175;
    for (int i = 0; i < 3; i++)
      d[i] = 8'($random(seed));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0000_0041, 32'hFFFF_FFFF);
    apb(1'b0, OFS_ADDR, 32'h0000_B2B4, 32'hFFFF_FFFF);
    apb(1'b0, OFS_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h00C, 32'h0000_0000, 32'hFFFF_FFFF);
    cfg(32'h0000_005D);
    check({29'h0, ckf, ckw, sup}, 32'h1);
    cfg(32'h0000_0018);
    check({29'h0, ckf, ckw, sup}, 32'h6);
    sw('{WA}, 1'b0);
    cfg(32'h0000_0021);
    sw('{WA, 8'h10, d[0], d[1], d[2]}, 1'b1);
    sr(8'h10, '{d[0], d[1], d[2]});
    check({31'h0, irq_n}, 32'h0);
    check(wake_n, 32'd3);
    apb(1'b1, OFS_STAT, 32'h0000_0001, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0000_0000, 32'h0000_0001);
    sw('{8'hA0, 8'h10}, 1'b0);
    check({31'h0, irq_n}, 32'h1);
    sw('{WA, 8'h10}, 1'b1);
    check({31'h0, irq_n}, 32'h0);
    cfg(32'h0000_0421);
    sw('{WA, 8'h20, d[1], 8'h30, d[2]}, 1'b1);
    cfg(32'h0000_0021);
    sr(8'h20, '{d[1]});
    sr(8'h30, '{d[2]});
    sr(8'h50, '{8'h00});
    sw('{8'hB2, 8'h10, 8'h5A}, 1'b1);
    sr(8'h10, '{d[0]});
    sw('{WA, 8'h00, 8'h03}, 1'b1);
    apb(1'b0, OFS_STAT, 32'h0000_0300, 32'h0000_FF00);
    sr(8'h10, '{8'h5A});
    cfg(32'h0000_0221);
    sw('{WA, 8'h00, 8'h02}, 1'b1);
    sr(8'h10, '{d[0]});
    cfg(32'h0000_0021);
    for (int k = 0; k < 8; k++)
    begin
      sstart();
      mdl_u.wr_byte(8'h08 | 8'(k), a);
      check({31'h0, a}, 32'h0);
      repeat (3) @(posedge pclk);
      check({31'h0, hs}, 32'h1);
      sstop();
      check({31'h0, hs}, 32'h0);
    end
    cfg(32'h0000_00A1);
    check({31'h0, hs}, 32'h1);
    cfg(32'h0000_0121);
    sstart();
    mdl_u.wr_byte(WA, a);
    apb(1'b0, OFS_STAT, 32'h0000_0004, 32'h0000_0004);
    repeat (2100) @(posedge pclk);
    apb(1'b0, OFS_STAT, 32'h0000_0000, 32'h0000_0004);
    sstop();
    cfg(32'h0000_0821);
    sstart();
    mdl_u.wr_byte(WA, a);
    @(posedge pclk);
    shut_n <= 1'b0;
    repeat (5) @(posedge pclk);
    shut_n <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, OFS_STAT, 32'h0000_0000, 32'h0000_0004);
    sstop();
    final_report();
  end
endmodule
